// ==== rtl/sbcfg_pkg.sv ====
// System bus configuration register bank: shared constants and carrier types.
// Assumes a 200 MHz core clock and an Avalon-MM slave with 32-bit data words.
package sbcfg_pkg;

    // ----------------------------------------------------------------
    // Register indices and byte addresses
    // ----------------------------------------------------------------
    localparam logic [15:0] BUS_CFG_IDX = 16'hff00;
    localparam logic [15:0] STACK_PAGE_IDX = 16'hff01;
    localparam logic [15:0] WAIT_CLK_IDX = 16'hff02;
    localparam int ADDR_W = 18;
    localparam logic [17:0] BUS_CFG_ADDR = {BUS_CFG_IDX, 2'b00};
    localparam logic [17:0] STACK_PAGE_ADDR = {STACK_PAGE_IDX, 2'b00};
    localparam logic [17:0] WAIT_CLK_ADDR = {WAIT_CLK_IDX, 2'b00};

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BUS_EXP_BIT = 7;
    localparam int CPU_MAX_BIT = 6;
    localparam int CS_EN_LSB = 0;
    localparam int BUS_REL_BIT = 7;
    localparam int WAIT_CODE_LSB = 4;
    localparam int CLK_SEL_BIT = 3;
    localparam int FOSC_ON_BIT = 2;

    // ----------------------------------------------------------------
    // Reset values and counts
    // ----------------------------------------------------------------
    localparam logic [7:0] BUS_CFG_RST_MCU = 8'h00;
    localparam logic [7:0] BUS_CFG_RST_MPU = 8'h81;
    localparam logic [7:0] STACK_PAGE_RST = 8'h00;
    localparam logic [7:0] WAIT_CLK_RST = 8'h0c;
    localparam logic [1:0] INSTR_HOLD_COUNT = 2'h2;
    localparam logic [3:0] WAIT_NONE = 4'h0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        SBCFG_SYNC0 = 4'b0001,
        SBCFG_SYNC1 = 4'b0010,
        SBCFG_LOAD = 4'b0100,
        SBCFG_RUN = 4'b1000
    } sbcfg_state_t;

    typedef struct packed {
        logic bus_exp;
        logic cpu_max;
        logic clk_fast;
        logic fosc_on;
    } sbcfg_mode_t;

    typedef struct packed {
        logic [2:0] cs_pin;
        logic ack_pin;
    } sbcfg_pins_t;

endpackage

// ==== rtl/sbcfg_wait_gen.sv ====
// Wait state generator for external bus cycles.
// Assumes the CPU pulses t3_in at state T3 and half_state_in once per half clock state.
`timescale 1ns/1ps
`default_nettype none
module sbcfg_wait_gen (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic t3_in,
    input wire logic ext_access_in,
    input wire logic fast_clk_in,
    input wire logic [2:0] wait_state_code_in,
    input wire logic half_state_in,
    output logic wait_active_out
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic start;

    // ----------------------------------------------------------------
    // Wait counter
    // ----------------------------------------------------------------
    // Internal accesses and the slow clock never stretch a cycle
    assign start = t3_in && ext_access_in && fast_clk_in;

    always_comb begin
        cnt_d = cnt_q;
        if (start && cnt_q == sbcfg_pkg::WAIT_NONE) begin
            cnt_d = {wait_state_code_in, 1'b0};
        end else if (half_state_in && cnt_q != sbcfg_pkg::WAIT_NONE) begin
            cnt_d = cnt_q - 4'h1;
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q <= sbcfg_pkg::WAIT_NONE;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Holds the bus between T3 and T4 while states remain
    assign wait_active_out = (cnt_q != sbcfg_pkg::WAIT_NONE);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_wait_load;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (start && cnt_q == 4'h0) |=> (cnt_q == {$past(wait_state_code_in), 1'b0});
    endproperty
    a_wait_load: assert property (p_wait_load) else $error("wait count not twice the code");

    property p_no_wait_gated;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (cnt_q == 4'h0 && t3_in && !(ext_access_in && fast_clk_in)) |=> !wait_active_out;
    endproperty
    a_no_wait_gated: assert property (p_no_wait_gated) else $error("wait inserted on internal or slow cycle");

    c_wait_max: cover property (@(posedge core_clk_in) disable iff (!rstn_in) cnt_q == 4'he);
endmodule
`default_nettype wire

// ==== rtl/sbcfg_regs.sv ====
// System bus configuration register bank: bus/CPU mode, chip-select pin routing,
// stack page, wait states, bus release pins, CPU clock and interrupt masking.
// Assumes an Avalon-MM master on core_clk_in; mode and bus request pins are asynchronous.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Bus config bit 7 selects expansion bus, bit 6 selects maximum CPU mode.
// - In processor mode the bus mode bit is fixed and reads as one.
// - Reset leaves single chip minimum in MCU mode, expansion minimum in MPU.
// - In expansion mode each set chip-select enable routes its chip select onto the shared pin.
// - Reset sets CS0 enable only in MPU mode; CS1 and CS2 start cleared.
// - In single chip mode the chip-select pins always show the output port.
// - Stack pointer carries never touch the page; the stack wraps in 64K.
// - All interrupts stay masked until bus config and stack page are written.
// - Every stack page write masks interrupts for one further instruction.
// - Wait code inserts twice its value in half-clock states, zero for none.
// - Bus release enable turns the shared pins into request and acknowledge.
// - Clock select bit runs the CPU on the fast oscillator; resets to one.
// - Fast oscillator on bit starts the oscillator; resets to one.
// - Waits go between T3 and T4, never internally or on slow clock.
module sbcfg_regs (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic mode_mcu_pin_in,
    input wire logic [17:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic [15:0] stack_pointer_in,
    output logic [23:0] stack_address_out,
    input wire logic instr_done_in,
    output logic int_mask_out,
    input wire logic [2:0] chip_select_n_in,
    input wire logic [2:0] output_port3_low_bits_in,
    input wire logic output_port3_bit3_in,
    input wire logic bus_ack_n_in,
    output sbcfg_pkg::sbcfg_pins_t pins_out,
    input wire logic bus_request_n_in,
    output logic input_port_bit3_out,
    output logic bus_request_n_out,
    input wire logic t3_in,
    input wire logic ext_access_in,
    input wire logic half_state_in,
    output logic wait_active_out,
    output sbcfg_pkg::sbcfg_mode_t mode_out
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    sbcfg_pkg::sbcfg_state_t state_q, state_d;
    logic [1:0] sync1_q, sync2_q;
    logic mcu_q, mcu_d;
    logic [7:0] bus_cfg_q, bus_cfg_d;
    logic [7:0] page_q, page_d;
    logic [7:0] wcc_q, wcc_d;
    logic wrote_bus_q, wrote_bus_d;
    logic wrote_page_q, wrote_page_d;
    logic [1:0] hold_q, hold_d;
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    sbcfg_pkg::sbcfg_pins_t pins_q, pins_d;
    logic [23:0] stack_q, stack_d;
    logic req_in_q, req_in_d;
    logic req_n_q, req_n_d;
    logic bus_exp;
    logic [2:0] cs_route;
    logic wr_acc;

    function automatic logic reg_hit(input logic [17:0] addr, input logic [17:0] reg_addr);
        return addr == reg_addr;
    endfunction

    assign bus_exp = bus_cfg_q[sbcfg_pkg::BUS_EXP_BIT] || !mcu_q;
    assign wr_acc = ack_q && avs_write_in && avs_byteenable_in[0];

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync1_q <= 2'h3;
            sync2_q <= 2'h3;
        end else begin
            sync1_q <= {bus_request_n_in, mode_mcu_pin_in};
            sync2_q <= sync1_q;
        end
    end

    // ----------------------------------------------------------------
    // Chip-select pin routing
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_cs
            // Single chip mode overrides the enables
            assign cs_route[gi] = bus_cfg_q[sbcfg_pkg::CS_EN_LSB + gi] && bus_exp;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        mcu_d = mcu_q;
        bus_cfg_d = bus_cfg_q;
        page_d = page_q;
        wcc_d = wcc_q;
        wrote_bus_d = wrote_bus_q;
        wrote_page_d = wrote_page_q;
        hold_d = hold_q;
        ack_d = 1'b0;
        rdata_d = rdata_q;
        unique case (state_q)
            sbcfg_pkg::SBCFG_SYNC0: begin
                state_d = sbcfg_pkg::SBCFG_SYNC1;
            end
            sbcfg_pkg::SBCFG_SYNC1: begin
                state_d = sbcfg_pkg::SBCFG_LOAD;
            end
            sbcfg_pkg::SBCFG_LOAD: begin
                // Strap is caught only once it has crossed both flops
                mcu_d = sync2_q[0];
                bus_cfg_d = sync2_q[0] ? sbcfg_pkg::BUS_CFG_RST_MCU : sbcfg_pkg::BUS_CFG_RST_MPU;
                state_d = sbcfg_pkg::SBCFG_RUN;
            end
            sbcfg_pkg::SBCFG_RUN: begin
                ack_d = (avs_read_in || avs_write_in) && !ack_q;
            end
            default: begin
                state_d = sbcfg_pkg::SBCFG_SYNC0;
            end
        endcase
        if (ack_d) begin
            rdata_d = 32'h0000_0000;
            if (avs_read_in && reg_hit(avs_address_in, sbcfg_pkg::BUS_CFG_ADDR)) begin
                rdata_d[7:0] = {bus_exp, bus_cfg_q[6:0]};
            end else if (avs_read_in && reg_hit(avs_address_in, sbcfg_pkg::STACK_PAGE_ADDR)) begin
                rdata_d[7:0] = page_q;
            end else if (avs_read_in && reg_hit(avs_address_in, sbcfg_pkg::WAIT_CLK_ADDR)) begin
                rdata_d[7:0] = wcc_q;
            end
        end
        if (wr_acc && reg_hit(avs_address_in, sbcfg_pkg::BUS_CFG_ADDR)) begin
            // Reserved bits simply store what is written
            bus_cfg_d = avs_writedata_in[7:0];
            bus_cfg_d[sbcfg_pkg::BUS_EXP_BIT] = avs_writedata_in[sbcfg_pkg::BUS_EXP_BIT] || !mcu_q;
            wrote_bus_d = 1'b1;
        end
        if (wr_acc && reg_hit(avs_address_in, sbcfg_pkg::STACK_PAGE_ADDR)) begin
            // No range check: the page limit is software's duty
            page_d = avs_writedata_in[7:0];
            wrote_page_d = 1'b1;
        end
        if (wr_acc && reg_hit(avs_address_in, sbcfg_pkg::WAIT_CLK_ADDR)) begin
            wcc_d = avs_writedata_in[7:0];
        end
        // The writing instruction ends first, then one more runs masked
        if (wr_acc && reg_hit(avs_address_in, sbcfg_pkg::STACK_PAGE_ADDR)) begin
            hold_d = sbcfg_pkg::INSTR_HOLD_COUNT;
        end else if (instr_done_in && hold_q != 2'h0) begin
            hold_d = hold_q - 2'h1;
        end
    end

    always_comb begin
        pins_d.cs_pin = 3'h0;
        for (int i = 0; i < 3; i++) begin
            pins_d.cs_pin[i] = cs_route[i] ? chip_select_n_in[i] : output_port3_low_bits_in[i];
        end
        pins_d.ack_pin = wcc_q[sbcfg_pkg::BUS_REL_BIT] ? bus_ack_n_in : output_port3_bit3_in;
        req_in_d = sync2_q[1];
        req_n_d = wcc_q[sbcfg_pkg::BUS_REL_BIT] ? sync2_q[1] : 1'b1;
        // Page comes only from the register: pointer carries are dropped
        stack_d = {page_q, stack_pointer_in};
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= sbcfg_pkg::SBCFG_SYNC0;
            mcu_q <= 1'b1;
            bus_cfg_q <= sbcfg_pkg::BUS_CFG_RST_MCU;
            page_q <= sbcfg_pkg::STACK_PAGE_RST;
            wcc_q <= sbcfg_pkg::WAIT_CLK_RST;
            wrote_bus_q <= 1'b0;
            wrote_page_q <= 1'b0;
            hold_q <= 2'h0;
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            pins_q <= '0;
            stack_q <= 24'h00_0000;
            req_in_q <= 1'b1;
            req_n_q <= 1'b1;
        end else begin
            state_q <= state_d;
            mcu_q <= mcu_d;
            bus_cfg_q <= bus_cfg_d;
            page_q <= page_d;
            wcc_q <= wcc_d;
            wrote_bus_q <= wrote_bus_d;
            wrote_page_q <= wrote_page_d;
            hold_q <= hold_d;
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            pins_q <= pins_d;
            stack_q <= stack_d;
            req_in_q <= req_in_d;
            req_n_q <= req_n_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign avs_waitrequest_out = !ack_q;
    assign avs_readdata_out = rdata_q;
    assign int_mask_out = !(wrote_bus_q && wrote_page_q) || (hold_q != 2'h0);
    assign pins_out = pins_q;
    assign stack_address_out = stack_q;
    assign input_port_bit3_out = req_in_q;
    assign bus_request_n_out = req_n_q;
    // One driver for the whole mode word, fields in struct order
    assign mode_out = {bus_exp, bus_cfg_q[sbcfg_pkg::CPU_MAX_BIT],
        wcc_q[sbcfg_pkg::CLK_SEL_BIT], wcc_q[sbcfg_pkg::FOSC_ON_BIT]};

    sbcfg_wait_gen u_wait (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .t3_in(t3_in),
        .ext_access_in(ext_access_in && bus_exp),
        .fast_clk_in(wcc_q[sbcfg_pkg::CLK_SEL_BIT]),
        .wait_state_code_in(wcc_q[sbcfg_pkg::WAIT_CODE_LSB +: 3]),
        .half_state_in(half_state_in),
        .wait_active_out(wait_active_out)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);

    property p_bus_write;
        (wr_acc && avs_address_in == 18'h3_fc00 && mcu_q)
            |=> (mode_out.bus_exp == $past(avs_writedata_in[7]) && mode_out.cpu_max == $past(avs_writedata_in[6]));
    endproperty
    a_bus_write: assert property (p_bus_write) else $error("mode bits not taken from write");

    property p_mpu_exp;
        (state_q == sbcfg_pkg::SBCFG_RUN && !mcu_q) |-> (mode_out.bus_exp && bus_cfg_q[7]);
    endproperty
    a_mpu_exp: assert property (p_mpu_exp) else $error("processor mode left expansion");

    property p_strap_load;
        (state_q == sbcfg_pkg::SBCFG_LOAD)
            |=> (bus_cfg_q == ($past(sync2_q[0]) ? 8'h00 : 8'h81) && mcu_q == $past(sync2_q[0]));
    endproperty
    a_strap_load: assert property (p_strap_load) else $error("reset mode not set from strap");

    property p_single_chip_pins;
        (rstn_in && !bus_exp) |=> (pins_out.cs_pin == $past(output_port3_low_bits_in));
    endproperty
    a_single_chip_pins: assert property (p_single_chip_pins) else $error("single chip pins not port");

    property p_cs_routed;
        (bus_exp && bus_cfg_q[2:0] == 3'h7) |=> (pins_out.cs_pin == $past(chip_select_n_in));
    endproperty
    a_cs_routed: assert property (p_cs_routed) else $error("chip select not routed");

    property p_stack_wrap;
        rstn_in |=> (stack_address_out == {$past(page_q), $past(stack_pointer_in)});
    endproperty
    a_stack_wrap: assert property (p_stack_wrap) else $error("stack page altered");

    property p_init_mask;
        !(wrote_bus_q && wrote_page_q) |-> int_mask_out;
    endproperty
    a_init_mask: assert property (p_init_mask) else $error("interrupts open before init");

    property p_page_hold;
        (wr_acc && avs_address_in == 18'h3_fc04) ##1 !instr_done_in |=> int_mask_out;
    endproperty
    a_page_hold: assert property (p_page_hold) else $error("no hold after stack page write");

    property p_release_off;
        (rstn_in && !wcc_q[7]) |=> (bus_request_n_out && pins_out.ack_pin == $past(output_port3_bit3_in));
    endproperty
    a_release_off: assert property (p_release_off) else $error("release pins active while disabled");

    property p_clk_reset;
        (state_q == sbcfg_pkg::SBCFG_LOAD) |-> (mode_out.clk_fast && mode_out.fosc_on && wcc_q == 8'h0c);
    endproperty
    a_clk_reset: assert property (p_clk_reset) else $error("clock bits not set after reset");

    property p_bus_answer;
        (state_q == sbcfg_pkg::SBCFG_RUN && (avs_read_in || avs_write_in)) |-> ##[0:1] !avs_waitrequest_out;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus request not answered");

    c_init_done: cover property ($fell(int_mask_out));
    c_page_write: cover property (wr_acc && avs_address_in == 18'h3_fc04);
    c_release_on: cover property (wcc_q[7] && !bus_request_n_out);
    c_cs_route: cover property (pins_out.cs_pin != output_port3_low_bits_in);
endmodule
`default_nettype wire

// ==== tb/sbcfg_far_model.sv ====
// Far-side model: DMA bus requester and the external bus cycle sequencer.
// Assumes one core clock; every output changes only just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module sbcfg_far_model (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic dma_want_in,
    input wire logic cycle_start_in,
    input wire logic ext_in,
    output logic bus_request_n_out,
    output logic t3_out,
    output logic ext_access_out,
    output logic half_state_out
);
    // ----------------------------------------------------------------
    // Request, T3 pulse and half-state stream
    // ----------------------------------------------------------------
    // Request stays low as long as the DMA side wants the bus; it never gives up early
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus_request_n_out <= 1'b1;
            t3_out <= 1'b0;
            ext_access_out <= 1'b0;
            half_state_out <= 1'b0;
        end else begin
            bus_request_n_out <= !dma_want_in;
            t3_out <= cycle_start_in;
            ext_access_out <= ext_in;
            half_state_out <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb_system_bus_config_regs.sv ====
// Self-checking bench for the system bus configuration register bank.
// Assumes the far-side model drives request, T3, external access and half-state inputs.
`timescale 1ns/1ps
`default_nettype none
module tb_system_bus_config_regs;
    typedef struct packed {
        logic [17:0] addr;
        logic [3:0] be;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [3:0] mode;
        logic [3:0] pins;
    } sbcfg_row_t;
    localparam logic [17:0] BA = sbcfg_pkg::BUS_CFG_ADDR;
    localparam logic [17:0] WA = sbcfg_pkg::WAIT_CLK_ADDR;
    localparam logic [17:0] SA = sbcfg_pkg::STACK_PAGE_ADDR;
    // Rows run in order: each expectation depends on the writes before it
    localparam sbcfg_row_t ROWS [9] = '{
        '{BA, 4'h1, 8'hc0, 8'hc0, 4'hf, 4'hf}, '{BA, 4'h1, 8'h87, 8'h87, 4'hb, 4'h1},
        '{BA, 4'h1, 8'h85, 8'h85, 4'hb, 4'h5}, '{BA, 4'h0, 8'hff, 8'h85, 4'hb, 4'h5},
        '{BA, 4'h1, 8'h3f, 8'h3f, 4'h3, 4'hf}, '{WA, 4'h1, 8'h73, 8'h73, 4'h0, 4'hf},
        '{WA, 4'h1, 8'h8c, 8'h8c, 4'h3, 4'he}, '{18'h3_fc0c, 4'h1, 8'hff, 8'h00, 4'h3, 4'he},
        '{SA, 4'h1, 8'h00, 8'h00, 4'h3, 4'he}};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic mcu = 1'b1;
    logic [17:0] adr = 18'h0_0000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0] be = 4'h0;
    logic [31:0] rdat;
    logic wreq;
    logic [15:0] sp = 16'h0000;
    logic [23:0] stk;
    logic idone = 1'b0;
    logic imask;
    logic [2:0] csn = 3'h0;
    logic [2:0] port_lo = 3'h7;
    logic port_b3 = 1'b1;
    logic ackn = 1'b0;
    sbcfg_pkg::sbcfg_pins_t pins;
    sbcfg_pkg::sbcfg_mode_t mode;
    logic dma_want = 1'b0;
    logic start = 1'b0;
    logic ext = 1'b0;
    logic bus_request_in_n, t3, ext_acc, half, inb3, bus_request_in_out, wact;
    logic [31:0] got;
    int miscompares = 0;
    int checks_done = 0;
    int n;

    initial begin
        forever #2.5 clk = ~clk;
    end

    sbcfg_far_model u_far (.core_clk_in(clk), .rstn_in(rstn), .dma_want_in(dma_want),
        .cycle_start_in(start), .ext_in(ext), .bus_request_n_out(bus_request_in_n), .t3_out(t3),
        .ext_access_out(ext_acc), .half_state_out(half));

    sbcfg_regs u_dut (.core_clk_in(clk), .rstn_in(rstn), .mode_mcu_pin_in(mcu),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
        .avs_byteenable_in(be), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
        .stack_pointer_in(sp), .stack_address_out(stk), .instr_done_in(idone),
        .int_mask_out(imask), .chip_select_n_in(csn), .output_port3_low_bits_in(port_lo),
        .output_port3_bit3_in(port_b3), .bus_ack_n_in(ackn), .pins_out(pins),
        .bus_request_n_in(bus_request_in_n), .input_port_bit3_out(inb3), .bus_request_n_out(bus_request_in_out),
        .t3_in(t3), .ext_access_in(ext_acc), .half_state_in(half), .wait_active_out(wact),
        .mode_out(mode));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Request is held until the edge at which waitrequest is seen low
    task automatic bus(input logic w, input logic [17:0] a, input logic [3:0] b, input logic [7:0] d);
        @(posedge clk);
        adr <= a;
        be <= b;
        wdat <= {24'h00_0000, d};
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wreq !== 1'b0);
        got = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic reset_dut(input logic m);
        rstn <= 1'b0;
        mcu <= m;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (5) @(posedge clk);
    endtask

    task automatic pulse_done();
        @(posedge clk);
        idone <= 1'b1;
        @(posedge clk);
        idone <= 1'b0;
        @(negedge clk);
    endtask

    // Launches one T3 and counts the cycles with wait states pending
    task automatic run_wait(input logic e);
        @(posedge clk);
        start <= 1'b1;
        ext <= e;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        repeat (40) begin
            @(posedge clk);
            if (wact === 1'b1) n++;
        end
        ext <= 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        reset_dut(1'b1);
        bus(1'b0, BA, 4'h1, 8'h00);
        chk(got, 32'h0000_0000);
        bus(1'b0, SA, 4'h1, 8'h00);
        chk(got, 32'h0000_0000);
        bus(1'b0, WA, 4'h1, 8'h00);
        chk(got, 32'h0000_000c);
        chk(mode, 4'h3);
        chk(imask, 1'b1);
        for (int i = 0; i < 9; i++) begin
            bus(1'b1, ROWS[i].addr, ROWS[i].be, ROWS[i].wdata);
            bus(1'b0, ROWS[i].addr, 4'h1, 8'h00);
            chk(got, {24'h00_0000, ROWS[i].rdata});
            chk(mode, ROWS[i].mode);
            chk(pins, ROWS[i].pins);
        end
        // Both registers now written; the stack page write still holds the mask
        chk(imask, 1'b1);
        pulse_done();
        chk(imask, 1'b1);
        pulse_done();
        chk(imask, 1'b0);
        dma_want <= 1'b1;
        repeat (5) @(posedge clk);
        chk(bus_request_in_out, 1'b0);
        chk(inb3, 1'b0);
        bus(1'b1, WA, 4'h1, 8'h0c);
        repeat (5) @(posedge clk);
        chk(bus_request_in_out, 1'b1);
        chk(pins.ack_pin, 1'b1);
        chk(inb3, 1'b0);
        dma_want <= 1'b0;
        bus(1'b1, BA, 4'h1, 8'h80);
        bus(1'b1, SA, 4'h1, 8'h17);
        sp <= 16'hffff;
        repeat (3) @(posedge clk);
        chk(stk, 24'h17_ffff);
        sp <= 16'h0000;
        repeat (3) @(posedge clk);
        chk(stk, 24'h17_0000);
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, WA, 4'h1, {1'b0, 3'(c), 4'hc});
            run_wait(1'b1);
            chk(32'(n), 32'(2 * c));
        end
        run_wait(1'b0);
        chk(32'(n), 32'h0000_0000);
        bus(1'b1, WA, 4'h1, 8'h74);
        run_wait(1'b1);
        chk(32'(n), 32'h0000_0000);
        // Second reset in mid-run, now with the strap in processor mode
        reset_dut(1'b0);
        bus(1'b0, BA, 4'h1, 8'h00);
        chk(got, 32'h0000_0081);
        chk(mode, 4'hb);
        chk(imask, 1'b1);
        bus(1'b1, BA, 4'h1, 8'h00);
        bus(1'b0, BA, 4'h1, 8'h00);
        chk(got, 32'h0000_0080);
        tally_and_finish();
    end
endmodule
`default_nettype wire
